// >>> logic/bps_defs.svh
`ifndef BPS_DEFS_SVH
`define BPS_DEFS_SVH

// system clock rate in hertz
`define BPS_CLK_HZ 25000000
// base tick period in milliseconds
`define BPS_TICK_MS 10
`define BPS_TICK_CYC ((`BPS_CLK_HZ / 1000) * `BPS_TICK_MS)
// delays in milliseconds, converted to ticks
`define BPS_START_DLY_MS 1000
`define BPS_START_DLY_TK (`BPS_START_DLY_MS / `BPS_TICK_MS)
`define BPS_TEST_DLY_MS 1000
`define BPS_TEST_DLY_TK (`BPS_TEST_DLY_MS / `BPS_TICK_MS)
`define BPS_RETURN_DLY_MS 3000
`define BPS_RETURN_DLY_TK (`BPS_RETURN_DLY_MS / `BPS_TICK_MS)
`define BPS_FAULT_WIN_MS 60000
`define BPS_FAULT_WIN_TK (`BPS_FAULT_WIN_MS / `BPS_TICK_MS)
`define BPS_MINUTE_MS 60000
`define BPS_MINUTE_TK (`BPS_MINUTE_MS / `BPS_TICK_MS)
// full charge hold time in hours
`define BPS_FULL_HOURS 12
`define BPS_FULL_TK (`BPS_FULL_HOURS * 3600 * (1000 / `BPS_TICK_MS))
// charging lamp blink half period in ticks
`define BPS_BLINK_TK 50
// operating time limits in minutes
`define BPS_MAX_MINUTES 5
// faults that force error lock
`define BPS_FAULT_LIMIT 5

`endif

// >>> logic/bps_pkg.sv
package bps_pkg;

    // selector positions
    typedef enum logic [1:0] {
        BPS_SEL_OFF = 2'h0,
        BPS_SEL_ON = 2'h1,
        BPS_SEL_TEST = 2'h2
    } bps_sel_t;

    // sequencer states, one-hot
    typedef enum logic [6:0] {
        BPS_ST_NORMAL = 7'h01,
        BPS_ST_START = 7'h02,
        BPS_ST_BACKUP = 7'h04,
        BPS_ST_TEST = 7'h08,
        BPS_ST_DONE = 7'h10,
        BPS_ST_FAULT = 7'h20,
        BPS_ST_LOCK = 7'h40
    } bps_state_t;

    // lamps toward the front panel
    typedef struct packed {
        logic inverting_active_lamp;
        logic charging_lamp;
        logic full_charge_lamp;
        logic low_battery_lamp;
        logic relay1_lamp;
        logic relay2_lamp;
        logic relay3_lamp;
        logic relay4_lamp;
        logic relay6_lamp;
    } bps_lamps_t;

    // relay drives
    typedef struct packed {
        logic transfer_relay_1;
        logic transfer_relay_2;
        logic transfer_relay_3;
        logic transfer_relay_4;
        logic transfer_relay_6;
    } bps_relays_t;

endpackage : bps_pkg

// >>> logic/bps_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for one pin
module bps_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic meta_q;

    // first flop read only by the second
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            level <= 1'b0;
        end else begin
            meta_q <= pin;
            level <= meta_q;
        end
    end
endmodule : bps_sync

// >>> logic/bps_tick.sv
`timescale 1ns/1ps
`include "bps_defs.svh"
// prescaler giving a one-cycle tick
module bps_tick #(
    parameter int unsigned TICK_CYC = `BPS_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    output logic tick
);
    logic [31:0] cnt_q;

    // free-running divider
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_q <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_q >= TICK_CYC - 1) begin
            cnt_q <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule : bps_tick

// >>> logic/bps_sequencer.sv
`timescale 1ns/1ps
`include "bps_defs.svh"
// How it works
// - backup starts on mains loss only with loops closed, battery good, time nonzero
// - restart input honoured only in the done state after a cycle
// - mains passes to output when idle with mains present
// - charging lamp blinks in normal mode unless full charge lamp lit
// - full charge lamp after twelve hours of good charging voltage
// - held test picks all five relays, inverting lamp on, charging off
// - test needs selector held one second
// - inverting starts one second after mains loss
// - backup picks relays 1, 2, 3 and 6, lamps inverting, relay1, relay2, relay3, relay6
// - timer expiry stops inverting and clears lamps
// - safety loop, battery disconnect or OFF stop backup at once
// - external stop command halts backup
// - undervoltage stops and latches low battery lamp till full or OFF
// - other faults stop, then resume when removed
// - fifth fault in sixty seconds locks until OFF then ON
// - mains return keeps backup running per policy
// - after backup with mains, relays drop and pass-through resumes
// - charging lamp never on with inverting lamp
// - policy on: three seconds after mains return, go to mains
// - policy off: stay on battery until timer expires
// - operating time zero to five minutes
// - duration from rockers one to four, clamped to five
// - entry needs battery above undervoltage threshold
module bps_sequencer #(
    parameter int unsigned TICK_CYC = `BPS_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic mains_present,
    input wire logic safety_loop_a,
    input wire logic safety_loop_b,
    input wire logic battery_disconnect_a,
    input wire logic battery_disconnect_b,
    input wire logic battery_above_uv,
    input wire logic charge_voltage_ok,
    input wire logic other_fault,
    input wire logic ext_stop_cmd,
    input wire logic passenger_restart_input,
    input wire bps_pkg::bps_sel_t mode_selector_switch,
    input wire logic [3:0] duration_switch_bank,
    input wire logic mains_return_policy,
    output bps_pkg::bps_lamps_t lamps,
    output bps_pkg::bps_relays_t relays,
    output logic inverter_run,
    output logic mains_pass_through
);
    import bps_pkg::*;

    logic tick;
    logic mains_s, loop_a_s, loop_b_s, bd_a_s, bd_b_s, uv_ok_s, chg_ok_s, flt_s, stop_s, restart_s;
    logic sel_on_s, sel_test_s;
    logic [3:0] dur_s;
    logic policy_s;
    bps_state_t state_q;
    logic [15:0] dly_q;
    logic [15:0] run_q;
    logic [23:0] full_q;
    logic full_q_lamp;
    logic low_bat_q;
    logic [2:0] flt_cnt_q;
    logic [15:0] win_q;
    logic [7:0] blink_q;
    logic blink_ph_q;
    logic [15:0] ret_q;
    logic off_seen_q;
    logic [2:0] minutes;
    logic loops_ok, start_ok, flt_now, restart_en;

    bps_tick #(.TICK_CYC(TICK_CYC)) u_tick (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick));

    // all pins through two flops
    bps_sync u_s0 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(mains_present), .level(mains_s));
    bps_sync u_s1 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(safety_loop_a), .level(loop_a_s));
    bps_sync u_s2 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(safety_loop_b), .level(loop_b_s));
    bps_sync u_s3 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(battery_disconnect_a), .level(bd_a_s));
    bps_sync u_s4 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(battery_disconnect_b), .level(bd_b_s));
    bps_sync u_s5 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(battery_above_uv), .level(uv_ok_s));
    bps_sync u_s6 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(charge_voltage_ok), .level(chg_ok_s));
    bps_sync u_s7 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(other_fault), .level(flt_s));
    bps_sync u_s8 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(ext_stop_cmd), .level(stop_s));
    bps_sync u_s9 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(passenger_restart_input), .level(restart_s));
    bps_sync u_sa (.sys_clk(sys_clk), .rst_n(rst_n), .pin(mode_selector_switch == BPS_SEL_ON),
        .level(sel_on_s));
    bps_sync u_sb (.sys_clk(sys_clk), .rst_n(rst_n), .pin(mode_selector_switch == BPS_SEL_TEST),
        .level(sel_test_s));
    // switch bank and policy switch are pins too
    bps_sync u_sd0 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(duration_switch_bank[0]), .level(dur_s[0]));
    bps_sync u_sd1 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(duration_switch_bank[1]), .level(dur_s[1]));
    bps_sync u_sd2 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(duration_switch_bank[2]), .level(dur_s[2]));
    bps_sync u_sd3 (.sys_clk(sys_clk), .rst_n(rst_n), .pin(duration_switch_bank[3]), .level(dur_s[3]));
    bps_sync u_sp (.sys_clk(sys_clk), .rst_n(rst_n), .pin(mains_return_policy), .level(policy_s));

    // duration clamp; switch bank is quasi-static
    assign minutes = (dur_s > 4'(`BPS_MAX_MINUTES)) ? 3'(`BPS_MAX_MINUTES) : dur_s[2:0];
    assign loops_ok = loop_a_s && loop_b_s && bd_a_s && bd_b_s;
    assign start_ok = loops_ok && uv_ok_s && !low_bat_q && (minutes != 3'h0);
    assign flt_now = flt_s || stop_s;
    assign restart_en = (state_q == BPS_ST_DONE) && restart_s;

    // main sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= BPS_ST_NORMAL;
            dly_q <= 16'h0;
            run_q <= 16'h0;
            ret_q <= 16'h0;
        end else begin
            unique case (state_q)
                BPS_ST_NORMAL: begin
                    dly_q <= 16'h0;
                    if (sel_test_s && start_ok) begin
                        state_q <= BPS_ST_TEST;
                    end else if (!mains_s && sel_on_s && start_ok) begin
                        state_q <= BPS_ST_START;
                    end
                end
                BPS_ST_TEST: begin
                    // test debounce then held
                    if (!sel_test_s || !loops_ok) begin
                        state_q <= BPS_ST_NORMAL;
                    end else if (tick && dly_q < 16'(`BPS_TEST_DLY_TK)) begin
                        dly_q <= dly_q + 16'h1;
                    end
                end
                BPS_ST_START: begin
                    if (mains_s || !sel_on_s || !start_ok) begin
                        state_q <= BPS_ST_NORMAL;
                    end else if (dly_q >= 16'(`BPS_START_DLY_TK)) begin
                        state_q <= BPS_ST_BACKUP;
                        run_q <= 16'h0;
                        ret_q <= 16'h0;
                    end else if (tick) begin
                        dly_q <= dly_q + 16'h1;
                    end
                end
                BPS_ST_BACKUP: begin
                    if (!sel_on_s || !loops_ok) begin
                        state_q <= BPS_ST_NORMAL;
                    end else if (!uv_ok_s) begin
                        state_q <= BPS_ST_NORMAL;
                    end else if (flt_now) begin
                        state_q <= BPS_ST_FAULT;
                    end else if (run_q >= 16'(minutes) * 16'(`BPS_MINUTE_TK)) begin
                        state_q <= mains_s ? BPS_ST_NORMAL : BPS_ST_DONE;
                    end else if (mains_s && policy_s && ret_q >= 16'(`BPS_RETURN_DLY_TK)) begin
                        state_q <= BPS_ST_NORMAL;
                    end else if (tick) begin
                        run_q <= run_q + 16'h1;
                        ret_q <= mains_s ? ret_q + 16'h1 : 16'h0;
                    end
                end
                BPS_ST_FAULT: begin
                    if (flt_cnt_q >= 3'(`BPS_FAULT_LIMIT)) begin
                        state_q <= BPS_ST_LOCK;
                    end else if (!sel_on_s || !loops_ok || mains_s) begin
                        state_q <= BPS_ST_NORMAL;
                    end else if (!flt_now) begin
                        state_q <= BPS_ST_BACKUP;
                    end
                end
                BPS_ST_DONE: begin
                    dly_q <= 16'h0;
                    if (mains_s || !sel_on_s) begin
                        state_q <= BPS_ST_NORMAL;
                    end else if (restart_en && start_ok) begin
                        state_q <= BPS_ST_START;
                    end
                end
                BPS_ST_LOCK: begin
                    if (off_seen_q && sel_on_s) begin
                        state_q <= BPS_ST_NORMAL;
                    end
                end
                default: state_q <= BPS_ST_NORMAL;
            endcase
        end
    end

    // off seen while locked
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            off_seen_q <= 1'b0;
        end else if (state_q != BPS_ST_LOCK) begin
            off_seen_q <= 1'b0;
        end else if (!sel_on_s && !sel_test_s) begin
            off_seen_q <= 1'b1;
        end
    end

    // fault counter within sixty-second window
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flt_cnt_q <= 3'h0;
            win_q <= 16'h0;
        end else if (state_q == BPS_ST_LOCK) begin
            flt_cnt_q <= 3'h0;
            win_q <= 16'h0;
        end else if (state_q == BPS_ST_BACKUP && flt_now) begin
            flt_cnt_q <= flt_cnt_q + 3'h1;
            if (flt_cnt_q == 3'h0) begin
                win_q <= 16'h0;
            end
        end else if (flt_cnt_q != 3'h0 && tick) begin
            if (win_q >= 16'(`BPS_FAULT_WIN_TK)) begin
                flt_cnt_q <= 3'h0;
                win_q <= 16'h0;
            end else begin
                win_q <= win_q + 16'h1;
            end
        end
    end

    // low battery latch
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            low_bat_q <= 1'b0;
        end else if (state_q == BPS_ST_BACKUP && !uv_ok_s) begin
            low_bat_q <= 1'b1;
        end else if (full_q_lamp || (!sel_on_s && !sel_test_s)) begin
            low_bat_q <= 1'b0;
        end
    end

    // twelve-hour charge timer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            full_q <= 24'h0;
            full_q_lamp <= 1'b0;
        end else if (!chg_ok_s || !mains_s || state_q != BPS_ST_NORMAL) begin
            full_q <= 24'h0;
            full_q_lamp <= 1'b0;
        end else if (full_q >= 24'(`BPS_FULL_TK)) begin
            full_q_lamp <= 1'b1;
        end else if (tick) begin
            full_q <= full_q + 24'h1;
        end
    end

    // blink phase for charging lamp
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            blink_q <= 8'h0;
            blink_ph_q <= 1'b0;
        end else if (tick) begin
            if (blink_q >= 8'(`BPS_BLINK_TK - 1)) begin
                blink_q <= 8'h0;
                blink_ph_q <= !blink_ph_q;
            end else begin
                blink_q <= blink_q + 8'h1;
            end
        end
    end

    logic test_act, inv_act;
    assign test_act = (state_q == BPS_ST_TEST) && dly_q >= 16'(`BPS_TEST_DLY_TK);
    assign inv_act = (state_q == BPS_ST_BACKUP) || test_act;

    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lamps <= '0;
            relays <= '0;
            inverter_run <= 1'b0;
            mains_pass_through <= 1'b0;
        end else begin
            inverter_run <= inv_act;
            mains_pass_through <= mains_s && !inv_act;
            lamps.inverting_active_lamp <= inv_act;
            lamps.charging_lamp <= !inv_act && state_q == BPS_ST_NORMAL && mains_s
                && blink_ph_q && !full_q_lamp;
            lamps.full_charge_lamp <= full_q_lamp;
            lamps.low_battery_lamp <= low_bat_q;
            lamps.relay1_lamp <= inv_act;
            lamps.relay2_lamp <= inv_act;
            lamps.relay3_lamp <= inv_act;
            lamps.relay4_lamp <= test_act;
            lamps.relay6_lamp <= inv_act;
            relays.transfer_relay_1 <= inv_act;
            relays.transfer_relay_2 <= inv_act;
            relays.transfer_relay_3 <= inv_act;
            relays.transfer_relay_4 <= test_act;
            relays.transfer_relay_6 <= inv_act;
        end
    end

    lamp_excl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(lamps.charging_lamp && lamps.inverting_active_lamp))
        else $error("charging lamp on while inverting");
    low_bat_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == BPS_ST_BACKUP && !uv_ok_s) |=> low_bat_q)
        else $error("low battery not latched");
    lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == BPS_ST_LOCK) |-> ##1 !inverter_run)
        else $error("inverting during lock");

    // fault limit reached while stopped
    sequence lock_due_s;
        (state_q == BPS_ST_FAULT) && (flt_cnt_q >= 3'(`BPS_FAULT_LIMIT));
    endsequence
    lock_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lock_due_s |=> (state_q == BPS_ST_LOCK))
        else $error("fault limit reached without lock");
    test_relays_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        test_act |=> (relays == 5'h1f))
        else $error("test mode relays not all picked");
    pass_excl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(mains_pass_through && inverter_run))
        else $error("mains passed through while inverting");
endmodule : bps_sequencer

// >>> verif/bps_far_side.sv
`timescale 1ns/1ps
// mains supply, elevator controller and door-open button
module bps_far_side (
    input wire logic sys_clk,
    input wire logic mains_on,
    input wire logic disconnect_closed,
    input wire logic battery_switch_closed,
    input wire logic door_pressed,
    input wire logic stop_request,
    output logic mains_present,
    output logic safety_loop_a,
    output logic safety_loop_b,
    output logic battery_disconnect_a,
    output logic battery_disconnect_b,
    output logic passenger_restart_input,
    output logic ext_stop_cmd
);
    // pins follow the bench levels, which move only at the falling edge
    always_comb begin
        mains_present = mains_on;
        safety_loop_a = disconnect_closed;
        safety_loop_b = disconnect_closed;
        battery_disconnect_a = battery_switch_closed;
        battery_disconnect_b = battery_switch_closed;
        passenger_restart_input = door_pressed;
        ext_stop_cmd = stop_request;
    end
endmodule : bps_far_side

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    import bps_pkg::*;
    localparam int TK = 2;
    localparam int SEC = 100 * TK;
    localparam int MIN = 60 * SEC;
    localparam int LIMIT = MIN + 40 * SEC;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic mains_on = 1'h1;
    logic loop_ok = 1'h1;
    logic bd_ok = 1'h1;
    logic door = 1'h0;
    logic stop_req = 1'h0;
    logic battery_above_uv = 1'h1;
    logic charge_voltage_ok = 1'h0;
    logic other_fault = 1'h0;
    bps_sel_t mode_selector_switch = BPS_SEL_OFF;
    logic [3:0] duration_switch_bank = 4'h1;
    logic mains_return_policy = 1'h1;
    logic mains_present, safety_loop_a, safety_loop_b, battery_disconnect_a, battery_disconnect_b;
    logic passenger_restart_input, ext_stop_cmd, inverter_run, mains_pass_through;
    bps_lamps_t lamps;
    bps_relays_t relays;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    bps_far_side bps_far_side_i (.sys_clk(sys_clk), .mains_on(mains_on), .disconnect_closed(loop_ok),
        .battery_switch_closed(bd_ok), .door_pressed(door), .stop_request(stop_req),
        .mains_present(mains_present), .safety_loop_a(safety_loop_a), .safety_loop_b(safety_loop_b),
        .battery_disconnect_a(battery_disconnect_a), .battery_disconnect_b(battery_disconnect_b),
        .passenger_restart_input(passenger_restart_input), .ext_stop_cmd(ext_stop_cmd));

    bps_sequencer #(.TICK_CYC(TK)) bps_sequencer_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .mains_present(mains_present), .safety_loop_a(safety_loop_a), .safety_loop_b(safety_loop_b),
        .battery_disconnect_a(battery_disconnect_a), .battery_disconnect_b(battery_disconnect_b),
        .battery_above_uv(battery_above_uv), .charge_voltage_ok(charge_voltage_ok),
        .other_fault(other_fault), .ext_stop_cmd(ext_stop_cmd),
        .passenger_restart_input(passenger_restart_input), .mode_selector_switch(mode_selector_switch),
        .duration_switch_bank(duration_switch_bank), .mains_return_policy(mains_return_policy),
        .lamps(lamps), .relays(relays), .inverter_run(inverter_run), .mains_pass_through(mains_pass_through));

    // clock and hang guard
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors = n_errors + 1;
            test_done();
        end
    end

    task automatic test_done();
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_vec(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_vec

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_cyc

    // bounded poll for the inverter to reach a level
    task automatic wait_run(input logic exp, input int lim);
        for (int i = 0; i < lim && inverter_run !== exp; i++) begin
            @(negedge sys_clk);
        end
        check_bit(inverter_run, exp);
    endtask : wait_run

    // mains on, loops closed, selector OFF then ON
    task automatic go_idle();
        @(negedge sys_clk);
        {mains_on, loop_ok, bd_ok, door, stop_req, battery_above_uv} = 6'h39;
        mode_selector_switch = BPS_SEL_OFF;
        wait_cyc(20);
        mode_selector_switch = BPS_SEL_ON;
        wait_cyc(50);
    endtask : go_idle

    // mains lost, then wait out the start delay
    task automatic lose_mains();
        mains_on = 1'h0;
        wait_cyc(SEC + 20);
    endtask : lose_mains

    task automatic t_normal();
        logic hi, lo;
        hi = 1'h0;
        lo = 1'h0;
        go_idle();
        check_bit(mains_pass_through, 1'h1);
        check_vec({4'h0, relays}, 9'h000);
        repeat (3 * SEC / 2) begin
            @(negedge sys_clk);
            hi = hi | (lamps.charging_lamp === 1'h1);
            lo = lo | (lamps.charging_lamp === 1'h0);
        end
        check_bit(hi & lo, 1'h1);
        door = 1'h1;
        wait_cyc(50);
        door = 1'h0;
        check_bit(inverter_run, 1'h0);
    endtask : t_normal

    task automatic t_start();
        go_idle();
        mains_on = 1'h0;
        wait_cyc(SEC - 20);
        check_bit(inverter_run, 1'h0);
        wait_cyc(40);
        check_bit(inverter_run, 1'h1);
        check_vec({4'h0, relays}, 9'h01d);
        check_vec(lamps, 9'h11d);
        loop_ok = 1'h0;
        wait_cyc(10);
        check_bit(inverter_run, 1'h0);
    endtask : t_start

    task automatic t_no_entry();
        go_idle();
        duration_switch_bank = 4'h0;
        mains_on = 1'h0;
        wait_cyc(3 * SEC / 2);
        check_bit(inverter_run, 1'h0);
        go_idle();
        duration_switch_bank = 4'h1;
        battery_above_uv = 1'h0;
        mains_on = 1'h0;
        wait_cyc(3 * SEC / 2);
        check_bit(inverter_run, 1'h0);
        go_idle();
        duration_switch_bank = 4'h8;
        lose_mains();
        check_bit(inverter_run, 1'h1);
        duration_switch_bank = 4'h1;
    endtask : t_no_entry

    // four faults resume, the fifth locks until OFF then ON
    task automatic t_lock();
        go_idle();
        lose_mains();
        for (int k = 1; k <= 5; k++) begin
            other_fault = 1'h1;
            wait_cyc(10);
            check_bit(inverter_run, 1'h0);
            other_fault = 1'h0;
            wait_cyc(20);
            check_bit(inverter_run, 1'(k < 5));
        end
        check_vec({4'h0, relays}, 9'h000);
        check_bit(lamps.inverting_active_lamp, 1'h0);
        go_idle();
        lose_mains();
        check_bit(inverter_run, 1'h1);
    endtask : t_lock

    task automatic t_stop_cmd();
        go_idle();
        lose_mains();
        stop_req = 1'h1;
        wait_cyc(10);
        check_bit(inverter_run, 1'h0);
        stop_req = 1'h0;
        wait_run(1'h1, 2 * SEC);
    endtask : t_stop_cmd

    task automatic t_undervolt();
        go_idle();
        lose_mains();
        battery_above_uv = 1'h0;
        wait_cyc(10);
        check_bit(inverter_run, 1'h0);
        check_bit(lamps.low_battery_lamp, 1'h1);
        battery_above_uv = 1'h1;
        wait_cyc(20);
        check_bit(lamps.low_battery_lamp, 1'h1);
        mode_selector_switch = BPS_SEL_OFF;
        wait_cyc(20);
        check_bit(lamps.low_battery_lamp, 1'h0);
    endtask : t_undervolt

    task automatic t_return_on();
        go_idle();
        mains_return_policy = 1'h1;
        lose_mains();
        mains_on = 1'h1;
        wait_cyc(3 * SEC - 40);
        check_bit(inverter_run, 1'h1);
        check_vec({4'h0, relays}, 9'h01d);
        wait_cyc(80);
        check_bit(inverter_run, 1'h0);
        check_bit(mains_pass_through, 1'h1);
        check_vec({4'h0, relays}, 9'h000);
    endtask : t_return_on

    task automatic t_expire();
        go_idle();
        mains_return_policy = 1'h0;
        mains_on = 1'h0;
        wait_cyc(3 * SEC / 2);
        mains_on = 1'h1;
        wait_cyc(4 * SEC);
        check_bit(inverter_run, 1'h1);
        mains_on = 1'h0;
        wait_cyc(MIN - 5 * SEC);
        check_bit(inverter_run, 1'h1);
        wait_cyc(SEC);
        check_bit(inverter_run, 1'h0);
        check_bit(lamps.inverting_active_lamp, 1'h0);
        check_vec({4'h0, relays}, 9'h000);
        door = 1'h1;
        wait_run(1'h1, 2 * SEC);
        door = 1'h0;
    endtask : t_expire

    task automatic t_test_mode();
        go_idle();
        mode_selector_switch = BPS_SEL_TEST;
        wait_cyc(SEC / 2);
        check_bit(lamps.inverting_active_lamp, 1'h0);
        mode_selector_switch = BPS_SEL_ON;
        wait_cyc(20);
        mode_selector_switch = BPS_SEL_TEST;
        wait_cyc(SEC + 40);
        check_vec({4'h0, relays}, 9'h01f);
        check_vec(lamps, 9'h11f);
        mode_selector_switch = BPS_SEL_ON;
        wait_cyc(40);
        check_vec({4'h0, relays}, 9'h000);
    endtask : t_test_mode

    // reset, then each scenario in turn
    initial begin
        wait_cyc(3);
        rst_n = 1'h1;
        t_normal();
        t_start();
        t_lock();
        t_no_entry();
        t_stop_cmd();
        t_undervolt();
        t_return_on();
        t_test_mode();
        t_expire();
        test_done();
    end
endmodule : testbench
